// *** shared/dcf_cfg.svh ***
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH

// default offsets chosen by the load strap at master reset
`define DCF_OFF_LO 16'h007F
`define DCF_OFF_HI 16'h03FF

// fixed first-word and retransmit latency, in ns
`define DCF_FWL_NS 60
// reference clock period in ns
`define DCF_CLK_NS 4

`endif

// *** shared/dcf_pkg.sv ***
package dcf_pkg;

    // offset programming method picked at master reset
    typedef enum logic {
        DCF_LOAD_PAR = 1'b0,
        DCF_LOAD_SER = 1'b1
    } dcf_load_type;

endpackage

// *** src/dcf_mem.sv ***
`timescale 1ns/1ps

module dcf_mem #(
    parameter int W  = 18,
    parameter int AW = 13
) (
    // clock
    input  wire logic          clk,
    // write side
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    // read side
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata_q
);

    logic [W-1:0] mem [0:(1<<AW)-1];

    // write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read, holds until the next read
    always_ff @(posedge clk) begin
        if (re) begin
            rdata_q <= mem[raddr];
        end
    end

endmodule

// *** src/dcf_flags.sv ***
`timescale 1ns/1ps
`include "dcf_cfg.svh"

// What this block does
// R1 - standard: almost empty when count at most n
// R2 - fall-through: almost empty when count at most n+1
// R3 - almost empty changes on read ticks only
// R4 - half full falls on write passing half
// R5 - half full rises on read reaching half
// R6 - standard: half full after D/2+1 writes
// R7 - fall-through: half full after (D-1)/2+2 writes
// R8 - read data bus is 18 bits wide
// R9 - full clears at write tick after read
// R10 - empty clears at read tick after write
// R11 - output ready two read ticks after write
// R12 - almost empty clears one read tick later
// R13 - input ready returns one write tick later
// R14 - almost full clears one write tick later
// R15 - standard first word after 60ns plus tick
// R16 - fall-through first word after 60ns, two ticks
// R17 - reader waits for empty high after retransmit
// R18 - writer keeps below depth minus two words
// R19 - retransmit: empty rises 60ns plus tick
// R20 - retransmit: output ready 60ns plus two ticks
// R21 - serial offset top bit index 12 or 13
// R22 - load low at reset: 127 offsets, parallel
// R23 - one description covers both depths
module dcf_flags #(
    parameter int W     = 18,
    parameter int DEPTH = 8192,
    parameter int AW    = 13
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    // device resets and straps
    input  wire logic         master_reset_n,
    input  wire logic         partial_reset_n,
    input  wire logic         first_word_fall_through_mode_select,
    input  wire logic         offset_load_n,
    // write port
    input  wire logic         write_tick,
    input  wire logic         write_en_n,
    input  wire logic [W-1:0] write_data,
    input  wire logic         serial_en_n,
    input  wire logic         serial_in,
    // read port
    input  wire logic         read_tick,
    input  wire logic         read_en_n,
    input  wire logic         retransmit_n,
    // data and flags
    output logic      [W-1:0] read_data_out,
    output logic              empty_flag_n,
    output logic              output_ready_n,
    output logic              full_flag_n,
    output logic              input_ready_n,
    output logic              almost_empty_flag_n,
    output logic              almost_full_flag_n,
    output logic              half_full_flag_n
);

    localparam int CW = AW + 1;
    localparam int X = AW - 1;
    localparam int FWL_CYC = (`DCF_FWL_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS;
    localparam logic [CW-1:0] DEP = CW'(DEPTH);
    localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic                  first_word_fall_through_mode_q;
    dcf_pkg::dcf_load_type load_q;
    logic [AW-1:0]         eoff_q;
    logic [AW-1:0]         foff_q;
    logic                  psel_q;
    logic [CW-1:0]         wptr_q;
    logic [CW-1:0]         rptr_q;
    logic [CW-1:0]         tot_q;
    logic [CW-1:0]         tot_d;
    logic [CW-1:0]         avail;
    logic [4:0]            lat_q;
    logic                  ovalid_q;
    logic                  ovalid_d;
    logic                  fetch_q;
    logic                  pend_q;
    logic [W-1:0]          mem_rdata;
    logic                  run;
    logic                  wr_acc;
    logic                  retx;
    logic                  lat_start;
    logic                  vis;
    logic                  std_rd;
    logic                  pop;
    logic                  load;
    logic                  fetch;
    logic                  mem_re;
    logic [CW-1:0]         ae_thr;
    logic [CW-1:0]         af_thr;
    logic [CW-1:0]         hf_thr;

    // thresholds, fall-through counts the output register word too
    function automatic logic [CW-1:0] with_out(input logic [CW-1:0] v, input logic f);
        with_out = f ? v + ONE : v;
    endfunction

    // request qualification
    always_comb begin
        run       = master_reset_n & partial_reset_n;
        avail     = wptr_q - rptr_q;
        wr_acc    = run & write_tick & !write_en_n & offset_load_n
                  & (first_word_fall_through_mode_q ? !input_ready_n : full_flag_n);
        retx      = run & read_tick & !retransmit_n;
        // first word into an empty store restarts the fixed wait
        lat_start = (wr_acc & (tot_q == '0)) | retx;
        vis       = (lat_q == 5'h00) & !lat_start;
        std_rd    = run & !first_word_fall_through_mode_q & read_tick & !read_en_n & empty_flag_n
                  & vis & (avail != '0) & !retx;
        pop       = run & first_word_fall_through_mode_q & read_tick & !read_en_n & ovalid_q & !retx;
        load      = run & first_word_fall_through_mode_q & read_tick & fetch_q & (!ovalid_q | pop) & !retx;
        fetch     = run & first_word_fall_through_mode_q & read_tick & vis & (avail != '0)
                  & (!fetch_q | load) & !retx;
        mem_re    = std_rd | fetch;
        ovalid_d  = retx ? 1'b0 : (load ? 1'b1 : (pop ? 1'b0 : ovalid_q));
        // retransmit rewinds to the first word since reset
        if (retx) begin
            tot_d = wptr_q + CW'(wr_acc);
        end else begin
            tot_d = tot_q + CW'(wr_acc) - CW'(std_rd | pop);
        end
        ae_thr = with_out({1'b0, eoff_q}, first_word_fall_through_mode_q);
        af_thr = with_out(DEP, first_word_fall_through_mode_q) - {1'b0, foff_q};
        hf_thr = with_out(HALF, first_word_fall_through_mode_q);
    end

    // mode and offset registers, kept across partial reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            first_word_fall_through_mode_q <= 1'b0;
            load_q <= dcf_pkg::DCF_LOAD_PAR;
            eoff_q <= AW'(`DCF_OFF_LO);
            foff_q <= AW'(`DCF_OFF_LO);
            psel_q <= 1'b0;
        end else if (!master_reset_n) begin
            first_word_fall_through_mode_q <= first_word_fall_through_mode_select;
            // R22 strap defaults
            load_q <= offset_load_n ? dcf_pkg::DCF_LOAD_SER : dcf_pkg::DCF_LOAD_PAR;
            eoff_q <= offset_load_n ? AW'(`DCF_OFF_HI) : AW'(`DCF_OFF_LO);
            foff_q <= offset_load_n ? AW'(`DCF_OFF_HI) : AW'(`DCF_OFF_LO);
            psel_q <= 1'b0;
        end else if (write_tick && !offset_load_n) begin
            if (load_q == dcf_pkg::DCF_LOAD_PAR && !write_en_n) begin
                // empty offset first, then full offset
                if (psel_q) begin
                    foff_q <= write_data[AW-1:0];
                end else begin
                    eoff_q <= write_data[AW-1:0];
                end
                psel_q <= !psel_q;
            end else if (load_q == dcf_pkg::DCF_LOAD_SER && !serial_en_n) begin
                // R21 bits 0..X of each offset shift through
                eoff_q <= {eoff_q[X-1:0], foff_q[X]};
                foff_q <= {foff_q[X-1:0], serial_in};
            end
        end
    end

    // R23 pointers sized from the address width parameter
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !run) begin
            wptr_q <= '0;
            rptr_q <= '0;
            tot_q  <= '0;
        end else begin
            wptr_q <= wptr_q + CW'(wr_acc);
            rptr_q <= retx ? '0 : rptr_q + CW'(mem_re);
            tot_q  <= tot_d;
        end
    end

    // R15 R19 fixed wait before a first word is visible
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !run) begin
            lat_q <= 5'h00;
        end else if (lat_start) begin
            lat_q <= 5'(FWL_CYC);
        end else if (lat_q != 5'h00) begin
            lat_q <= lat_q - 5'h01;
        end
    end

    // storage array
    dcf_mem #(
        .W  (W),
        .AW (AW)
    ) u_mem (
        .clk     (ref_clk),
        .we      (wr_acc),
        .waddr   (wptr_q[AW-1:0]),
        .wdata   (write_data),
        .re      (mem_re),
        .raddr   (rptr_q[AW-1:0]),
        .rdata_q (mem_rdata)
    );

    // R16 fall-through pipe: fetch on one tick, present on the next
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !run) begin
            ovalid_q <= 1'b0;
            fetch_q  <= 1'b0;
            pend_q   <= 1'b0;
        end else begin
            ovalid_q <= ovalid_d;
            fetch_q  <= retx ? 1'b0 : (fetch ? 1'b1 : (load ? 1'b0 : fetch_q));
            pend_q   <= std_rd;
        end
    end

    // R8 output register, old word stays when nothing is read
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            read_data_out <= '0;
        end else if (pend_q || load) begin
            read_data_out <= mem_rdata;
        end
    end

    // R3 read-side flags move on read ticks only
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !run) begin
            empty_flag_n        <= 1'b0;
            output_ready_n      <= 1'b1;
            almost_empty_flag_n <= 1'b0;
        end else if (read_tick) begin
            // R10 R19 empty rises on the tick after data is visible
            empty_flag_n        <= vis & (tot_d != '0);
            // R11 R20 ready once the word reached the output register
            output_ready_n      <= !ovalid_d;
            // R1 R2 R12 compare against n or n+1
            almost_empty_flag_n <= tot_d > ae_thr;
        end
    end

    // write-side flags move on write ticks only
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !run) begin
            full_flag_n        <= 1'b1;
            input_ready_n      <= 1'b0;
            almost_full_flag_n <= 1'b1;
        end else if (write_tick) begin
            // R9 full space seen at the next write tick
            full_flag_n        <= tot_d < DEP;
            // R13 one extra word for the output register
            input_ready_n      <= !(tot_d < DEP + ONE);
            // R14 almost full against D-m or D+1-m
            almost_full_flag_n <= tot_d < af_thr;
        end
    end

    // half full is set by writes and cleared by reads
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !run) begin
            half_full_flag_n <= 1'b1;
        // R4 R6 R7 write pushing past half
        end else if (wr_acc && tot_d > hf_thr) begin
            half_full_flag_n <= 1'b0;
        // R5 read bringing it back to half
        end else if (read_tick && tot_d <= hf_thr) begin
            half_full_flag_n <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_ae_read_only: assert property ((run && !read_tick) |=> $stable(almost_empty_flag_n)) // R3
        else $error("almost empty moved without a read tick");
    chk_ae_std_level: assert property ((run && read_tick && !first_word_fall_through_mode_q) // R1
        |=> almost_empty_flag_n == ($past(tot_d) > {1'b0, $past(eoff_q)}))
        else $error("almost empty wrong in standard mode");
    chk_ae_first_word_fall_through_mode_level: assert property ((run && read_tick && first_word_fall_through_mode_q) // R2
        |=> almost_empty_flag_n == ($past(tot_d) > {1'b0, $past(eoff_q)} + ONE))
        else $error("almost empty wrong in fall-through mode");
    chk_hf_write_set: assert property ((wr_acc && tot_d > hf_thr) |=> !half_full_flag_n) // R4
        else $error("half full not set by write");
    chk_hf_read_clear: assert property ((run && read_tick && !wr_acc && tot_d <= hf_thr) // R5
        |=> half_full_flag_n)
        else $error("half full not cleared by read");
    chk_full_on_tick: assert property (($rose(full_flag_n) && $past(run)) |-> $past(write_tick)) // R9
        else $error("full cleared off a write tick");
    chk_empty_on_tick: assert property ($rose(empty_flag_n) |-> $past(read_tick) && $past(lat_q) == 5'h00) // R10
        else $error("empty cleared early");
    chk_fwl_hold: assert property ((run && lat_q != 5'h00 && !empty_flag_n) |=> !empty_flag_n) // R15
        else $error("first word visible before wait ended");
    chk_or_hold: assert property ((run && lat_q != 5'h00 && output_ready_n && !fetch_q) // R16
        |=> output_ready_n)
        else $error("output ready before wait ended");
    chk_retx_empty: assert property (retx |=> !empty_flag_n && lat_q == 5'(FWL_CYC)) // R19
        else $error("retransmit did not restart the wait");
    chk_ir_on_tick: assert property (($fell(input_ready_n) && $past(run)) |-> $past(write_tick)) // R13
        else $error("input ready changed off a write tick");
    chk_af_level: assert property ((run && write_tick) // R14
        |=> almost_full_flag_n == ($past(tot_d) < $past(af_thr)))
        else $error("almost full level wrong");

    cov_first_word: cover property (run && wr_acc && tot_q == '0);
    cov_half_full: cover property ($fell(half_full_flag_n));
    cov_retransmit: cover property (retx);
    cov_first_word_fall_through_mode_ready: cover property ($fell(output_ready_n));

endmodule

// *** testbench/dcf_far_end.sv ***
`timescale 1ns/1ps

// behavioural writing and reading logic on the far side of the flags block
module dcf_far_end (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // bench requests
    input  wire logic        wr_req,
    input  wire logic        rd_req,
    input  wire logic        first_word_fall_through_mode,
    // device flag and ports
    input  wire logic        empty_flag_n,
    output logic             write_tick,
    output logic             write_en_n,
    output logic      [17:0] write_data,
    output logic             read_tick,
    output logic             read_en_n
);
    logic [17:0] word_q;

    // both device clocks run free, fall-through needs a running read clock
    always_ff @(posedge ref_clk) begin
        write_tick <= !sys_rst;
        read_tick  <= !sys_rst;
    end

    // next word, advanced on every issued write, refused ones too
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            word_q <= 18'h00100;
        end else if (wr_req) begin
            word_q <= word_q + 18'h00001;
        end
    end

    // idle bus shows the inverse so a stale word never matches
    assign write_en_n = !wr_req;
    assign write_data = wr_req ? word_q : ~word_q;
    assign read_en_n  = !(rd_req && (first_word_fall_through_mode || empty_flag_n));
endmodule

// *** testbench/tb_dcf_flags.sv ***
`timescale 1ns/1ps
`include "dcf_cfg.svh"

module tb_dcf_flags;
    // small depth keeps the run short; offsets stay at the strap default until the serial load at the end
    localparam int DEPTH = 256;
    localparam int OFF   = `DCF_OFF_LO;
    localparam int LAT   = (`DCF_FWL_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS;

    logic        ref_clk, sys_rst, master_reset_n, partial_reset_n, first_word_fall_through_mode_select, offset_load_n;
    logic        wr_req, rd_req, retransmit_n, write_tick, write_en_n, read_tick, read_en_n;
    logic        serial_en_n, serial_in;
    logic [17:0] write_data, read_data_out;
    logic        empty_flag_n, output_ready_n, full_flag_n, input_ready_n;
    logic        almost_empty_flag_n, almost_full_flag_n, half_full_flag_n;
    int          num_errors, checks_done, n, nw, base;
    int          cycles = 0;

    dcf_far_end far (.ref_clk(ref_clk), .sys_rst(sys_rst), .wr_req(wr_req), .rd_req(rd_req),
        .first_word_fall_through_mode(first_word_fall_through_mode_select), .empty_flag_n(empty_flag_n), .write_tick(write_tick), .write_en_n(write_en_n),
        .write_data(write_data), .read_tick(read_tick), .read_en_n(read_en_n));

    dcf_flags #(.W(18), .DEPTH(DEPTH), .AW(8)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n), .first_word_fall_through_mode_select(first_word_fall_through_mode_select),
        .offset_load_n(offset_load_n), .write_tick(write_tick), .write_en_n(write_en_n),
        .write_data(write_data), .serial_en_n(serial_en_n), .serial_in(serial_in), .read_tick(read_tick),
        .read_en_n(read_en_n), .retransmit_n(retransmit_n), .read_data_out(read_data_out),
        .empty_flag_n(empty_flag_n), .output_ready_n(output_ready_n), .full_flag_n(full_flag_n),
        .input_ready_n(input_ready_n), .almost_empty_flag_n(almost_empty_flag_n),
        .almost_full_flag_n(almost_full_flag_n), .half_full_flag_n(half_full_flag_n));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic chk_data(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // k back to back writes; returns at the edge taking the last one
    task automatic wr_cnt(input int k);
        @(posedge ref_clk) wr_req <= 1'b1;
        repeat (k) @(posedge ref_clk);
        wr_req <= 1'b0;
        nw += k;
    endtask

    task automatic rd_cnt(input int k);
        @(posedge ref_clk) rd_req <= 1'b1;
        repeat (k) @(posedge ref_clk);
        rd_req <= 1'b0;
    endtask

    // sample on the falling edge so clocked updates have landed
    task automatic settle(input int k);
        repeat (k) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // edges until the word is visible, bounded
    task automatic meas(input logic first_word_fall_through_mode);
        n = 0;
        @(negedge ref_clk);
        while ((first_word_fall_through_mode ? output_ready_n : !empty_flag_n) !== 1'b0 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    // low load strap picks the 127-word offsets
    task automatic dev_reset(input logic first_word_fall_through_mode, input logic ld);
        @(posedge ref_clk);
        master_reset_n <= 1'b0;
        first_word_fall_through_mode_select    <= first_word_fall_through_mode;
        offset_load_n  <= ld;
        repeat (2) @(posedge ref_clk);
        master_reset_n <= 1'b1;
        offset_load_n  <= 1'b1;
    endtask

    // empty offset then full offset, msb first, one bit per write tick
    task automatic ser_load(input logic [15:0] sv);
        @(posedge ref_clk);
        offset_load_n <= 1'b0;
        serial_en_n   <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_in <= sv[i];
            @(posedge ref_clk);
        end
        offset_load_n <= 1'b1;
        serial_en_n   <= 1'b1;
    endtask

    initial begin
        sys_rst = 1'b1; master_reset_n = 1'b1; partial_reset_n = 1'b1; first_word_fall_through_mode_select = 1'b0;
        offset_load_n = 1'b1; wr_req = 1'b0; rd_req = 1'b0; retransmit_n = 1'b1;
        num_errors = 0; checks_done = 0; nw = 0; serial_en_n = 1'b1; serial_in = 1'b0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        dev_reset(1'b0, 1'b0);
        settle(1);
        chk_bit(empty_flag_n, 1'b0);
        chk_bit(full_flag_n, 1'b1);
        chk_bit(half_full_flag_n, 1'b1);
        chk_bit(almost_full_flag_n, 1'b1);
        chk_bit(almost_empty_flag_n, 1'b0);
        wr_cnt(1);
        meas(1'b0);
        chk_bit(n >= LAT + 1 && n <= LAT + 2, 1'b1);
        rd_cnt(1);
        settle(2);
        chk_data(read_data_out, 18'h00100);
        chk_bit(empty_flag_n, 1'b0);
        wr_cnt(OFF);
        settle(LAT + 4);
        chk_bit(almost_empty_flag_n, 1'b0);
        wr_cnt(1);
        settle(LAT + 4);
        chk_bit(almost_empty_flag_n, 1'b1);
        chk_bit(half_full_flag_n, 1'b1);
        wr_cnt(1);
        settle(0);
        chk_bit(half_full_flag_n, 1'b0);
        chk_bit(almost_full_flag_n, 1'b0);
        rd_cnt(1);
        settle(1);
        chk_bit(half_full_flag_n, 1'b1);
        chk_bit(almost_full_flag_n, 1'b1);
        wr_cnt(DEPTH / 2);
        settle(0);
        chk_bit(full_flag_n, 1'b0);
        wr_cnt(1);
        rd_cnt(1);
        settle(1);
        chk_bit(full_flag_n, 1'b1);
        settle(1);
        chk_data(read_data_out, 18'h00102);
        @(posedge ref_clk) partial_reset_n <= 1'b0;
        @(posedge ref_clk) partial_reset_n <= 1'b1;
        settle(0);
        chk_bit(empty_flag_n, 1'b0);
        chk_bit(half_full_flag_n, 1'b1);
        base = nw;
        wr_cnt(3);
        meas(1'b0);
        rd_cnt(2);
        @(posedge ref_clk) retransmit_n <= 1'b0;
        @(posedge ref_clk) retransmit_n <= 1'b1;
        meas(1'b0);
        chk_bit(n >= LAT + 1 && n <= LAT + 2, 1'b1);
        rd_cnt(1);
        settle(2);
        chk_data(read_data_out, 18'h00100 + base[17:0]);
        dev_reset(1'b1, 1'b0);
        settle(1);
        chk_bit(input_ready_n, 1'b0);
        base = nw;
        wr_cnt(1);
        meas(1'b1);
        chk_bit(n >= LAT + 2 && n <= LAT + 3, 1'b1);
        chk_data(read_data_out, 18'h00100 + base[17:0]);
        wr_cnt(OFF);
        settle(LAT + 4);
        chk_bit(almost_empty_flag_n, 1'b0);
        wr_cnt(1);
        settle(LAT + 4);
        chk_bit(almost_empty_flag_n, 1'b1);
        chk_bit(half_full_flag_n, 1'b1);
        wr_cnt(1);
        settle(0);
        chk_bit(half_full_flag_n, 1'b0);
        dev_reset(1'b0, 1'b1);
        ser_load(16'h0210);
        wr_cnt(2);
        settle(LAT + 4);
        chk_bit(almost_empty_flag_n, 1'b0);
        wr_cnt(1);
        settle(LAT + 4);
        chk_bit(almost_empty_flag_n, 1'b1);
        stop_test();
    end
endmodule
